// ### dv/gdc_bus_model.sv
// system bus memory and dma-requesting peripheral behind the channel
`timescale 1ns/1ps
module gdc_bus_model (
    input  logic        clk,
    input  logic        resetn,
    input  logic [23:0] busAddr,
    input  logic        busStrobe,
    input  logic        busWrite,
    input  logic        busUpper,
    input  logic        busLower,
    input  logic [15:0] busWdata,
    output logic [15:0] busRdata,
    output logic        dataTransferAck,
    output logic        busFault,
    input  logic        periphAck,
    output logic        periphRequest,
    output logic        periphEnd,
    input  logic [3:0]  lat,
    input  logic [24:0] faultAddr,
    input  logic        reqOn,
    input  logic        endOnce,
    input  logic        wide
);
    logic [7:0]  mem [0:255];
    logic [3:0]  cnt_q;
    logic [15:0] last_q;
    logic        used_q;
    wire  [7:0]  a  = busAddr[7:0];
    wire  [7:0]  ae = {a[7:1], 1'b0};
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    // released bus shows the inverse of its last value, never a stale copy
    assign busRdata = busStrobe ? (wide ? {mem[ae], mem[ae | 8'h01]} : {mem[a], mem[a]}) : ~last_q;
    assign periphRequest = reqOn;
    assign periphEnd = endOnce && !used_q && periphAck;
    // answer after lat+1 strobed cycles, fault on the armed address
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 4'h0;
            dataTransferAck <= 1'b0;
            busFault <= 1'b0;
            used_q <= 1'b0;
        end else begin
            dataTransferAck <= 1'b0;
            busFault <= 1'b0;
            if (busStrobe) last_q <= busRdata;
            if (busStrobe && !dataTransferAck && !busFault) begin
                cnt_q <= (cnt_q == lat) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == lat && faultAddr == {1'b1, busAddr}) busFault <= 1'b1;
                else if (cnt_q == lat) dataTransferAck <= 1'b1;
            end
            if (busStrobe && dataTransferAck && busWrite && wide && busUpper) mem[ae] <= busWdata[15:8];
            if (busStrobe && dataTransferAck && busWrite && busLower) mem[wide ? ae | 8'h01 : a] <= busWdata[7:0];
            if (periphEnd && dataTransferAck) used_q <= 1'b1;
            if (!endOnce) used_q <= 1'b0;
        end
    end
endmodule // gdc_bus_model

// ### dv/gdc_checker.sv
// port-level assertions for the general dma channel
`timescale 1ns/1ps
module gdc_checker (
    input logic        clk,
    input logic        resetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic [23:0] busAddr,
    input logic [2:0]  spaceCodePins,
    input logic        busStrobe,
    input logic        busWrite,
    input logic        busUpper,
    input logic        dataTransferAck,
    input logic        busFault,
    input logic        periphAck,
    input logic        endOut,
    input logic        endOe
);
    logic [7:0]  codes_q;
    logic [15:0] cfg_q;
    logic        wide_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // mirror of programmed fields, taken at the completing apb edge only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            codes_q <= 8'h00;
            cfg_q   <= 16'h0000;
            wide_q  <= 1'b1;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == 12'h008) codes_q <= pwdata[7:0];
            if (paddr == 12'h010) cfg_q <= pwdata[15:0];
            if (paddr == 12'h018) wide_q <= pwdata[0];
        end
    end
    a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_read_codes: assert property (busStrobe && !busWrite |-> spaceCodePins == codes_q[2:0])
        else $error("wrong space code on read");
    a_write_codes: assert property (busStrobe && busWrite |-> spaceCodePins == codes_q[6:4])
        else $error("wrong space code on write");
    a_cycle_hold: assert property (busStrobe && !dataTransferAck && !busFault |=> busStrobe && $stable(busAddr) && $stable(busWrite))
        else $error("bus cycle changed before its answer");
    a_cycle_end: assert property (busStrobe && (dataTransferAck || busFault) |=> !busStrobe)
        else $error("strobe held after answer");
    a_fault_stop: assert property (busStrobe && busFault |=> !busStrobe [*4])
        else $error("bus activity after fault");
    a_ack_mode: assert property (!cfg_q[11] |-> !periphAck)
        else $error("peripheral ack in internal mode");
    a_narrow_lanes: assert property (busStrobe && !wide_q |-> !busUpper)
        else $error("upper lane used on narrow bus");
    a_end_write: assert property (endOe && busStrobe && !cfg_q[11] |-> busWrite && endOut)
        else $error("end driven outside last write");
    c_fault: cover property (busStrobe && busFault);
    c_periph: cover property (periphAck && dataTransferAck);
    c_end: cover property (endOe && busStrobe);
endmodule // gdc_checker

bind gdc_dma_channel gdc_checker chk_u (.*);

// ### dv/gdc_tb.sv
// register-level testbench for the general dma channel
`timescale 1ns/1ps
`include "gdc_consts.vh"
module testbench;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic pready, pslverr, busStrobe, busWrite, busUpper, busLower, dataTransferAck, busFault;
    logic periphRequest, periphAck, endOut, endOe, periphEnd, endIn;
    logic [23:0] busAddr;
    logic [2:0]  spaceCodePins;
    logic [15:0] busWdata, busRdata;
    logic [3:0]  lat = 4'h0;
    logic [24:0] faultAddr = 25'h0;
    logic reqOn = 0, endOnce = 0, wide = 1;
    int err_total = 0, total_checks = 0;
    assign endIn = endOe ? endOut : periphEnd;
    always #2 clk = ~clk;
    gdc_dma_channel dut_u (.*);
    gdc_bus_model mem_u (.*);
    task close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task apb(input bit w, input [11:0] a, input [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin err_total++; close_out; end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [11:0] a, input [31:0] d); apb(1, a, d); endtask
    task rdc(input string nm, input [11:0] a, input [31:0] exp); apb(0, a, 0); chk(nm, rd, exp); endtask
    task go(input [23:0] s, d, input [15:0] n, input [15:0] c);
        wr(`GDC_OFS_SRC_PTR, s);
        wr(`GDC_OFS_DST_PTR, d);
        wr(`GDC_OFS_COUNT, n);
        wr(`GDC_OFS_CONFIG, c);
    endtask
    // poll the run bit; the channel clears it when it stops
    task idle;
        int n;
        n = 0;
        do begin apb(0, `GDC_OFS_CONFIG, 0); n++; end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin err_total++; close_out; end
    endtask
    task cmpmem(input [7:0] s, d, input int n);
        for (int i = 0; i < n; i++) chk("mem", mem_u.mem[8'(d + i)], 8'(s + i) ^ 8'h5A);
    endtask
    initial begin repeat (100000) @(posedge clk); err_total++; close_out; end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("config", `GDC_OFS_CONFIG, 32'h0);
        rdc("events", `GDC_OFS_EVENTS, 32'h0);
        rdc("width", `GDC_OFS_BUSWIDTH, 32'h1);
        rdc("unmapped", 12'h01C, 32'h0);
        chk("slverr", slv, 1);
        wr(`GDC_OFS_SPACE, 32'h52);
        rdc("codes", `GDC_OFS_SPACE, 32'hDA);
        // every request source, one word operand each
        for (int m = 0; m < 4; m++) begin
            reqOn <= 1'b0;
            go(24'h10, 24'h40 + 8 * m, 16'h0002, 16'h03A1 | (m << 10));
            reqOn <= 1'b1;
            idle();
            cmpmem(8'h10, 8'h40 + 8 * m, 2);
            rdc("src", `GDC_OFS_SRC_PTR, 32'h12);
            rdc("dst", `GDC_OFS_DST_PTR, 32'h42 + 8 * m);
            rdc("count", `GDC_OFS_COUNT, 32'h0);
            rdc("config", `GDC_OFS_CONFIG, 32'h03A0 | (m << 10));
            rdc("events", `GDC_OFS_EVENTS, 32'h1);
            wr(`GDC_OFS_EVENTS, 32'h0);
            rdc("events", `GDC_OFS_EVENTS, 32'h1);
            wr(`GDC_OFS_EVENTS, 32'h1);
            rdc("events", `GDC_OFS_EVENTS, 32'h0);
        end
        // odd count ends with a single byte
        go(24'h20, 24'h60, 16'h0003, 16'h03A1);
        idle();
        cmpmem(8'h20, 8'h60, 3);
        chk("mem", mem_u.mem[8'h63], 8'h63 ^ 8'h5A);
        rdc("events", `GDC_OFS_EVENTS, 32'h1);
        wr(`GDC_OFS_EVENTS, 32'h1);
        go(24'hFFFFFE, 24'h50, 16'h0002, 16'h03A1);
        idle();
        rdc("wrap", `GDC_OFS_SRC_PTR, 32'h0);
        cmpmem(8'hFE, 8'h50, 2);
        // byte peripheral at fixed even address ends early while packing
        endOnce <= 1'b1;
        go(24'h80, 24'hC0, 16'h0004, 16'h0961);
        idle();
        rdc("events", `GDC_OFS_EVENTS, 32'h9);
        rdc("count", `GDC_OFS_COUNT, 32'h2);
        chk("pack", {mem_u.mem[8'hC0], mem_u.mem[8'hC1]}, {2{8'h80 ^ 8'h5A}});
        wr(`GDC_OFS_EVENTS, 32'h9);
        rdc("events", `GDC_OFS_EVENTS, 32'h0);
        endOnce <= 1'b0;
        // narrow bus ignores the word widths
        wide <= 1'b0;
        wr(`GDC_OFS_BUSWIDTH, 32'h0);
        go(24'h30, 24'h70, 16'h0002, 16'h03A1);
        idle();
        cmpmem(8'h30, 8'h70, 2);
        wr(`GDC_OFS_BUSWIDTH, 32'h1);
        wide <= 1'b1;
        wr(`GDC_OFS_EVENTS, 32'h1);
        // slow memory, stop mid-block then resume; wait covers one slow operand
        lat <= 4'h6;
        go(24'h90, 24'hB0, 16'h0008, 16'h03A1);
        repeat (12) @(posedge clk);
        wr(`GDC_OFS_CONFIG, 32'h03A0);
        repeat (40) @(posedge clk);
        apb(0, `GDC_OFS_COUNT, 0);
        chk("halted", rd != 0 && rd != 8 && !rd[0], 1);
        rdc("events", `GDC_OFS_EVENTS, 32'h0);
        wr(`GDC_OFS_CONFIG, 32'h03A1);
        idle();
        cmpmem(8'h90, 8'hB0, 8);
        wr(`GDC_OFS_EVENTS, 32'h1);
        lat <= 4'h0;
        // faults on read and on write
        faultAddr <= {1'b1, 24'h10};
        go(24'h10, 24'hA0, 16'h0004, 16'h03A1);
        idle();
        rdc("events", `GDC_OFS_EVENTS, 32'h4);
        rdc("src", `GDC_OFS_SRC_PTR, 32'h10);
        wr(`GDC_OFS_EVENTS, 32'h4);
        faultAddr <= {1'b1, 24'hA0};
        go(24'h10, 24'hA0, 16'h0004, 16'h03A1);
        idle();
        rdc("events", `GDC_OFS_EVENTS, 32'h2);
        rdc("count", `GDC_OFS_COUNT, 32'h4);
        faultAddr <= 25'h0;
        wr(`GDC_OFS_CONFIG, 32'h03A2);
        rdc("config", `GDC_OFS_CONFIG, 32'h0);
        rdc("events", `GDC_OFS_EVENTS, 32'h0);
        close_out();
    end
endmodule // testbench

// ### logic/gdc_consts.vh
// constants for the general dma channel: register map, fields, encodings
`ifndef GDC_CONSTS_VH
`define GDC_CONSTS_VH

// register byte offsets on the apb bus
`define GDC_OFS_SRC_PTR     12'h000
`define GDC_OFS_DST_PTR     12'h004
`define GDC_OFS_SPACE       12'h008
`define GDC_OFS_COUNT       12'h00C
`define GDC_OFS_CONFIG      12'h010
`define GDC_OFS_EVENTS      12'h014
`define GDC_OFS_BUSWIDTH    12'h018

// channel_config field positions
`define GDC_CFG_RUN         0
`define GDC_CFG_SRST        1
`define GDC_CFG_BT_LO       2
`define GDC_CFG_DW_LO       4
`define GDC_CFG_SW_LO       6
`define GDC_CFG_DSTEP       8
`define GDC_CFG_SSTEP       9
`define GDC_CFG_REQ_LO      10
`define GDC_CFG_FIRQ        12
`define GDC_CFG_NIRQ        13
`define GDC_CFG_ECO         14

// channel_events bit positions
`define GDC_EV_DONE         0
`define GDC_EV_WFAULT       1
`define GDC_EV_RFAULT       2
`define GDC_EV_NOTALIGN     3

// reset values
`define GDC_CONFIG_RST      16'h0000
`define GDC_EVENTS_RST      4'h0
`define GDC_BUSWIDTH_RST    1'h1

// request_source encodings
`define GDC_REQ_INT_LIMIT   2'h0
`define GDC_REQ_INT_MAX     2'h1
`define GDC_REQ_EXT_LEVEL   2'h2
`define GDC_REQ_EXT_EDGE    2'h3

// width encodings
`define GDC_WIDTH_BYTE      2'h1
`define GDC_WIDTH_WORD      2'h2

`endif

// ### logic/gdc_dma_channel.v
// general dma channel: apb register file, dual-address bus master, peripheral handshake
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "gdc_consts.vh"

// Operation
// - run bit starts; clearing halts after operand
// - run bit self-clears when block completes
// - source pointer drives address on reads
// - destination pointer drives address on writes
// - pointers hold or step one/two/four, wrapping
// - space code pins show source/destination code
// - 16-bit byte counter, zero means 64K
// - stop at zero count, odd counts allowed
// - events set status regardless of enables
// - status readable, write-one clears, reset clears
// - early peripheral end still finishes, flags misalignment
// - odd count ending never flags misalignment
// - read fault terminates, sets read fault bit
// - write fault terminates, sets write fault bit
// - done bit only on error-free termination
// - external request, ack on peripheral accesses
// - internal modes drive end on last cycle
// - external modes end input, output on exhaustion
// - read into holding buffer, then write out
// - advance pointers, subtract bytes after operand
// - 8-bit bus ignores widths, two cycles
// - 16-bit bus splits odd words, packs sizes
// - request source selects four request modes
// - width fields encode byte 01, word 10
// - soft reset aborts, clears config and status
module gdc_dma_channel (
    input  wire        clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [23:0] busAddr,
    output reg  [2:0]  spaceCodePins,
    output reg         busStrobe,
    output reg         busWrite,
    output reg         busUpper,
    output reg         busLower,
    output reg  [15:0] busWdata,
    input  wire [15:0] busRdata,
    input  wire        dataTransferAck,
    input  wire        busFault,
    input  wire        periphRequest,
    output reg         periphAck,
    input  wire        endIn,
    output reg         endOut,
    output reg         endOe
);
    // one-hot sequencer states
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_ISSUE = 3'h2;
    localparam [2:0] ST_WAIT  = 3'h4;

    // register file, sequencer and handshake state
    reg  [1:0]  rstSync_q;
    wire        rstn;
    reg  [31:0] srcPtr_q;
    reg  [31:0] dstPtr_q;
    reg  [7:0]  space_q;
    reg  [15:0] count_q;
    reg  [15:0] config_q;
    reg  [3:0]  events_q;
    reg         busWide_q;
    reg         srst_q;
    reg  [2:0]  state_q;
    reg         phaseWr_q;
    reg         idx_q;
    reg         two_q;
    reg         lastOp_q;
    reg         endSeen_q;
    reg  [15:0] hold_q;
    reg         reqPrev_q;
    reg         pend_q;

    // derived per-cycle decode
    wire        run      = config_q[`GDC_CFG_RUN];
    wire [1:0]  reqSrc   = config_q[`GDC_CFG_REQ_LO+1:`GDC_CFG_REQ_LO];
    wire        extMode  = reqSrc[1];
    // only the word code selects a word; reserved codes act as byte
    wire        srcWord  = busWide_q & (config_q[`GDC_CFG_SW_LO+1:`GDC_CFG_SW_LO]
                           == `GDC_WIDTH_WORD);
    wire        dstWord  = busWide_q & (config_q[`GDC_CFG_DW_LO+1:`GDC_CFG_DW_LO]
                           == `GDC_WIDTH_WORD);
    wire        sideWord = phaseWr_q ? dstWord : srcWord;
    wire [23:0] sidePtr  = phaseWr_q ? dstPtr_q[23:0] : srcPtr_q[23:0];
    wire        stepEn   = phaseWr_q ? config_q[`GDC_CFG_DSTEP] : config_q[`GDC_CFG_SSTEP];
    wire        wordCyc  = sideWord & two_q & ~sidePtr[0];
    wire        stride2  = ~sideWord & two_q;
    wire        lastCyc  = wordCyc | ~two_q | idx_q;
    wire        perSide  = config_q[`GDC_CFG_ECO] ? phaseWr_q : ~phaseWr_q;
    wire        busy     = (state_q != ST_IDLE);
    // packed byte side: a fixed pointer repeats its address,
    // a stepping one moves by two so the peripheral keeps its lane
    wire [23:0] cycOfs   = ~idx_q   ? 24'h000000 :
                           ~stride2 ? 24'h000001 :
                           stepEn   ? 24'h000002 : 24'h000000;
    wire [23:0] cycAddr  = sidePtr + cycOfs;
    wire [23:0] stepAmt  = ~stepEn ? 24'h000000 :
                           wordCyc ? 24'h000002 :
                           two_q   ? (stride2 ? 24'h000004 : 24'h000002) : 24'h000001;
    wire [23:0] nextPtr  = sidePtr + stepAmt;
    wire [15:0] opBytes  = two_q ? 16'h0002 : 16'h0001;
    wire [15:0] countNext = count_q - opBytes;
    wire [7:0]  rdByte   = (busWide_q & ~cycAddr[0]) ? busRdata[15:8] : busRdata[7:0];
    wire [7:0]  wrByte   = idx_q ? hold_q[7:0] : hold_q[15:8];
    wire        endPin   = endIn & ~endOe;
    wire        endSample = endPin & (~extMode | perSide);
    // level mode follows the pin, edge mode a latched edge
    wire        reqReady = ~extMode | (reqSrc == `GDC_REQ_EXT_LEVEL ? periphRequest : pend_q);
    wire        startOp  = (state_q == ST_IDLE) & run & reqReady & ~srst_q;
    wire        startTwo = busWide_q & (srcWord | dstWord) & (count_q != 16'h0001);
    // a fault wins over an acknowledge in one cycle
    wire        cycEnd   = (state_q == ST_WAIT) & dataTransferAck & ~busFault;
    wire        cycFault = (state_q == ST_WAIT) & busFault;
    wire        opDone   = cycEnd & phaseWr_q & lastCyc;
    // block ends only at an operand boundary
    wire        endNow   = endSeen_q | endSample;
    wire        finish   = opDone & ((countNext == 16'h0000) | endNow);

    // apb decode: access phase has one wait cycle so prdata comes from a flop
    wire        apbAcc   = psel & penable;
    wire        apbWr    = apbAcc & pready & pwrite;
    wire        mapped   = (paddr <= `GDC_OFS_BUSWIDTH) & (paddr[1:0] == 2'h0);
    wire        lockRegs = run | busy;
    // setup registers refuse writes while running
    wire        wrSrc    = apbWr & (paddr == `GDC_OFS_SRC_PTR) & ~lockRegs;
    wire        wrDst    = apbWr & (paddr == `GDC_OFS_DST_PTR) & ~lockRegs;
    wire        wrSpace  = apbWr & (paddr == `GDC_OFS_SPACE) & ~lockRegs;
    wire        wrCount  = apbWr & (paddr == `GDC_OFS_COUNT) & ~lockRegs;
    wire        wrCfg    = apbWr & (paddr == `GDC_OFS_CONFIG);
    wire        wrEv     = apbWr & (paddr == `GDC_OFS_EVENTS);
    wire        wrWidth  = apbWr & (paddr == `GDC_OFS_BUSWIDTH) & ~lockRegs;

    // combinational results
    reg  [31:0] rdMux;
    reg  [3:0]  evSet;
    reg  [3:0]  events_d;
    reg  [15:0] config_d;

    // reset release through two flops
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    // everything else resets on the released copy
    assign rstn = rstSync_q[1];

    // read data mux; reserved bits of space codes read as one
    always @* begin
        rdMux = 32'h00000000;
        case (paddr)
            `GDC_OFS_SRC_PTR:  rdMux = srcPtr_q;
            `GDC_OFS_DST_PTR:  rdMux = dstPtr_q;
            `GDC_OFS_SPACE:    rdMux = {24'h000000, 1'b1, space_q[6:4], 1'b1, space_q[2:0]};
            `GDC_OFS_COUNT:    rdMux = {16'h0000, count_q};
            `GDC_OFS_CONFIG:   rdMux = {16'h0000, config_q[15:2], srst_q, config_q[0]};
            `GDC_OFS_EVENTS:   rdMux = {28'h0000000, events_q};
            `GDC_OFS_BUSWIDTH: rdMux = {31'h00000000, busWide_q};
            default:           rdMux = 32'h00000000;
        endcase
    end

    // status events: hardware set wins over a write-one clear in the same cycle
    always @* begin
        evSet = 4'h0;
        evSet[`GDC_EV_RFAULT]  = cycFault & ~phaseWr_q;
        evSet[`GDC_EV_WFAULT]  = cycFault & phaseWr_q;
        evSet[`GDC_EV_DONE]    = finish;
        // early end on the first of two byte-side peripheral accesses
        evSet[`GDC_EV_NOTALIGN] = cycEnd & endSample & extMode & perSide
                                  & stride2 & ~idx_q;
        events_d = (events_q & ~(wrEv ? pwdata[3:0] : 4'h0)) | evSet;
    end

    // config: hardware clears of the run bit, then a software write that overrides them
    always @* begin
        config_d = config_q;
        if (finish | cycFault) begin
            config_d[`GDC_CFG_RUN] = 1'b0;
        end
        if (wrCfg) begin
            config_d = pwdata[15:0];
            config_d[15] = 1'b0;
            config_d[`GDC_CFG_SRST] = 1'b0;
        end
    end

    // apb slave handshake and register storage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            srcPtr_q  <= 32'h00000000;
            dstPtr_q  <= 32'h00000000;
            space_q   <= 8'h00;
            count_q   <= 16'h0000;
            config_q  <= `GDC_CONFIG_RST;
            events_q  <= `GDC_EVENTS_RST;
            busWide_q <= `GDC_BUSWIDTH_RST;
            srst_q    <= 1'b0;
        end else begin
            pready  <= apbAcc & ~pready;
            pslverr <= apbAcc & ~pready & ~mapped;
            if (apbAcc & ~pready) begin
                prdata <= rdMux;
            end
            if (srst_q) begin
                // soft reset completes in one cycle, then drops its own bit
                config_q <= `GDC_CONFIG_RST;
                events_q <= `GDC_EVENTS_RST;
                srst_q   <= 1'b0;
            end else begin
                config_q <= config_d;
                events_q <= events_d;
                srst_q   <= wrCfg & pwdata[`GDC_CFG_SRST];
            end
            // pointers move only after a whole side
            if (wrSrc) begin
                srcPtr_q <= {8'h00, pwdata[23:0]};
            end else if (cycEnd & ~phaseWr_q & lastCyc) begin
                srcPtr_q <= {8'h00, nextPtr};
            end
            if (wrDst) begin
                dstPtr_q <= {8'h00, pwdata[23:0]};
            end else if (opDone) begin
                dstPtr_q <= {8'h00, nextPtr};
            end
            if (wrSpace) begin
                space_q <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            end
            // counter drops once the write side ends
            if (wrCount) begin
                count_q <= pwdata[15:0];
            end else if (opDone) begin
                count_q <= countNext;
            end
            // width is a setup choice, locked mid-block
            if (wrWidth) begin
                busWide_q <= pwdata[0];
            end
        end
    end

    // cycle-steal requests: edges latch a pending request, ack start consumes it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reqPrev_q <= 1'b0;
            pend_q    <= 1'b0;
        end else begin
            reqPrev_q <= periphRequest;
            if (srst_q) begin
                pend_q <= 1'b0;
            end else if (run & periphRequest & ~reqPrev_q) begin
                pend_q <= 1'b1;
            end else if (state_q == ST_ISSUE & perSide & ~idx_q) begin
                pend_q <= 1'b0;
            end
        end
    end

    // operand sequencer: read cycles into the holding buffer, then write cycles
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q       <= ST_IDLE;
            phaseWr_q     <= 1'b0;
            idx_q         <= 1'b0;
            two_q         <= 1'b0;
            lastOp_q      <= 1'b0;
            endSeen_q     <= 1'b0;
            hold_q        <= 16'h0000;
            busAddr       <= 24'h000000;
            spaceCodePins <= 3'h0;
            busStrobe     <= 1'b0;
            busWrite      <= 1'b0;
            busUpper      <= 1'b0;
            busLower      <= 1'b0;
            busWdata      <= 16'h0000;
            periphAck     <= 1'b0;
            endOut        <= 1'b0;
            endOe         <= 1'b0;
        end else if (srst_q) begin
            // abort any running bus cycle at once
            state_q   <= ST_IDLE;
            busStrobe <= 1'b0;
            periphAck <= 1'b0;
            endOut    <= 1'b0;
            endOe     <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // halt point: run bit is looked at only between operands
                    if (startOp) begin
                        state_q   <= ST_ISSUE;
                        phaseWr_q <= 1'b0;
                        idx_q     <= 1'b0;
                        two_q     <= startTwo;
                        lastOp_q  <= (count_q == (startTwo ? 16'h0002 : 16'h0001));
                        endSeen_q <= 1'b0;
                    end
                end
                ST_ISSUE: begin
                    state_q       <= ST_WAIT;
                    busAddr       <= cycAddr;
                    spaceCodePins <= phaseWr_q ? space_q[6:4] : space_q[2:0];
                    busStrobe     <= 1'b1;
                    busWrite      <= phaseWr_q;
                    // narrow bus always uses the low lane
                    busUpper      <= wordCyc | (busWide_q & ~cycAddr[0]);
                    busLower      <= wordCyc | ~busWide_q | cycAddr[0];
                    busWdata      <= wordCyc ? hold_q : {wrByte, wrByte};
                    periphAck     <= extMode & perSide;
                    // internal: last cycle of block; external: peripheral side of it
                    endOut        <= lastOp_q & (extMode ? perSide : (phaseWr_q & lastCyc));
                    endOe         <= lastOp_q & (extMode ? perSide : (phaseWr_q & lastCyc));
                end
                ST_WAIT: begin
                    if (busFault) begin
                        // fault ends the block with no done indication
                        state_q   <= ST_IDLE;
                        busStrobe <= 1'b0;
                        periphAck <= 1'b0;
                        endOut    <= 1'b0;
                        endOe     <= 1'b0;
                    end else if (dataTransferAck) begin
                        busStrobe <= 1'b0;
                        periphAck <= 1'b0;
                        endOut    <= 1'b0;
                        endOe     <= 1'b0;
                        if (endSample) begin
                            endSeen_q <= 1'b1;
                        end
                        if (~phaseWr_q) begin
                            // latch read data when the cycle is acknowledged
                            if (wordCyc) begin
                                hold_q <= busRdata;
                            end else if (idx_q) begin
                                hold_q[7:0] <= rdByte;
                            end else begin
                                hold_q[15:8] <= rdByte;
                            end
                        end
                        // an early end still lets the second access run
                        if (lastCyc) begin
                            idx_q     <= 1'b0;
                            phaseWr_q <= ~phaseWr_q;
                            state_q   <= phaseWr_q ? ST_IDLE : ST_ISSUE;
                        end else begin
                            idx_q   <= 1'b1;
                            state_q <= ST_ISSUE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // gdc_dma_channel
